// *** src/prs_pin_sync.sv ***
// two-stage synchroniser for the device pins
`timescale 1ns/1ns
module prs_pin_sync #(
    parameter int unsigned WIDTH = prs_pkg::PIN_COUNT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] next_stageOne;
    logic [WIDTH-1:0] next_pinSync;

    always_comb begin
        next_stageOne = pinIn;
        next_pinSync = stageOne;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stageOne <= '0;
            pinSync <= '0;
        end else begin
            stageOne <= next_stageOne;
            pinSync <= next_pinSync;
        end
    end

endmodule : prs_pin_sync

// *** src/prs_pkg.sv ***
// constants, types and helpers for the power-up, power-down and security block
package prs_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int unsigned NUM_CELLS = 10;
    localparam int unsigned SIG_WORDS = 2;
    localparam int unsigned PIN_COUNT = 12;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POLARITY = 8'h04;
    localparam logic [7:0] ADDR_OUT_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_PRELOAD = 8'h0C;
    localparam logic [7:0] ADDR_SECURE = 8'h10;
    localparam logic [7:0] ADDR_VERIFY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_CELLS = 8'h1C;
    localparam logic [7:0] ADDR_SIG_LO = 8'h20;
    localparam logic [7:0] ADDR_SIG_HI = 8'h24;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned CTRL_PD_ENABLE_BIT = 0;
    localparam int unsigned SECURE_FUSE_BIT = 0;
    localparam int unsigned STAT_SLEEP_BIT = 0;
    localparam int unsigned STAT_SECURED_BIT = 1;
    localparam int unsigned STAT_PORST_BIT = 2;
    localparam int unsigned STAT_REFUSED_BIT = 3;
    localparam int unsigned VERIFY_OE_LSB = 16;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic PD_ENABLE_RESET = 1'b0;
    localparam logic FUSE_RESET = 1'b0;
    localparam logic [9:0] POLARITY_RESET = 10'h000;
    localparam logic [9:0] OUT_ENABLE_RESET = 10'h000;
    localparam logic [31:0] SIG_RESET = 32'h0000_0000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned POWER_UP_RESET_TIME_NS = 600;
    localparam int unsigned POWER_UP_RESET_CYCLES =
        (POWER_UP_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PORST_LAST =
        8'(POWER_UP_RESET_CYCLES - 1);

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        PRS_PORST = 3'b001,
        PRS_RUN = 3'b010,
        PRS_SLEEP = 3'b100
    } prs_state_t;

    // address is one of the mapped words
    function automatic logic prs_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr == ADDR_CTRL || addr == ADDR_POLARITY) begin
            hit = 1'b1;
        end else if (addr == ADDR_OUT_ENABLE || addr == ADDR_PRELOAD) begin
            hit = 1'b1;
        end else if (addr == ADDR_SECURE || addr == ADDR_VERIFY) begin
            hit = 1'b1;
        end else if (addr == ADDR_STATUS || addr == ADDR_CELLS) begin
            hit = 1'b1;
        end else if (addr == ADDR_SIG_LO || addr == ADDR_SIG_HI) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : prs_mapped

    // address selects a signature word
    function automatic logic prs_is_sig(input logic [7:0] addr);
        return (addr == ADDR_SIG_LO) || (addr == ADDR_SIG_HI);
    endfunction : prs_is_sig

endpackage : prs_pkg

// *** src/prs_sequencer_top.sv ***
// macrocell housekeeping: power-up clear, power-down hold, preload, security
`timescale 1ns/1ns
module prs_sequencer_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire logic arrayClkPin,
    input wire logic [9:0] logicInPin,
    input wire logic input_or_sleep_pin,
    output logic [9:0] cellOut,
    output logic [9:0] cellOutEn
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [11:0] pinSync;
    logic arrayClkS;
    logic sleepPinS;
    logic [9:0] logicInS;

    prs_pin_sync #(
        .WIDTH(prs_pkg::PIN_COUNT)
    ) uPinSync (
        .clk_sys(clk_sys),
        .srst(srst),
        .pinIn({input_or_sleep_pin, arrayClkPin, logicInPin}),
        .pinSync(pinSync)
    );

    assign logicInS = pinSync[9:0];
    assign arrayClkS = pinSync[10];
    assign sleepPinS = pinSync[11];

    // ****************************************************************
    // apb decode
    // ****************************************************************
    logic setupPh;
    logic accessPh;
    logic xferDone;
    logic wrDone;
    logic [31:0] sigRdData;
    logic pdEnable;
    logic fuseSet;
    logic refused;
    logic [9:0] polarity;
    logic [9:0] outEnable;
    logic [9:0] cells;
    logic [7:0] porstCnt;
    prs_pkg::prs_state_t state;

    assign setupPh = psel & ~penable;
    assign accessPh = psel & penable;
    assign xferDone = accessPh & pready;
    assign wrDone = xferDone & pwrite & ~pslverr;

    prs_sig_mem uSigMem (
        .clk_sys(clk_sys),
        .srst(srst),
        .wrEn(wrDone & prs_pkg::prs_is_sig(paddr)),
        .wrSel(paddr == prs_pkg::ADDR_SIG_HI),
        .wrData(pwdata),
        .rdSel(paddr == prs_pkg::ADDR_SIG_HI),
        .rdData(sigRdData)
    );

    logic [31:0] rdMux;
    logic accessErr;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // read mux and refusal check for the current access
    always_comb begin
        rdMux = 32'h0000_0000;
        accessErr = 1'b0;
        if (!prs_pkg::prs_mapped(paddr)) begin
            accessErr = 1'b1;
        end else if (paddr == prs_pkg::ADDR_CTRL) begin
            rdMux[prs_pkg::CTRL_PD_ENABLE_BIT] = pdEnable;
        end else if (paddr == prs_pkg::ADDR_POLARITY) begin
            rdMux[9:0] = polarity;
        end else if (paddr == prs_pkg::ADDR_OUT_ENABLE) begin
            rdMux[9:0] = outEnable;
        end else if (paddr == prs_pkg::ADDR_PRELOAD) begin
            accessErr = pwrite & (fuseSet | (state != prs_pkg::PRS_RUN));
        end else if (paddr == prs_pkg::ADDR_SECURE) begin
            rdMux[prs_pkg::SECURE_FUSE_BIT] = fuseSet;
        end else if (paddr == prs_pkg::ADDR_VERIFY) begin
            accessErr = fuseSet;
            if (!fuseSet) begin
                rdMux[9:0] = polarity;
                rdMux[prs_pkg::VERIFY_OE_LSB +: 10] = outEnable;
            end
        end else if (paddr == prs_pkg::ADDR_STATUS) begin
            rdMux[prs_pkg::STAT_SLEEP_BIT] = state == prs_pkg::PRS_SLEEP;
            rdMux[prs_pkg::STAT_SECURED_BIT] = fuseSet;
            rdMux[prs_pkg::STAT_PORST_BIT] = state == prs_pkg::PRS_PORST;
            rdMux[prs_pkg::STAT_REFUSED_BIT] = refused;
        end else if (paddr == prs_pkg::ADDR_CELLS) begin
            rdMux[9:0] = cells;
        end else begin
            rdMux = sigRdData;
        end
    end

    // one wait state: answer on the second access edge
    always_comb begin
        next_pready = accessPh & ~pready;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (accessPh && !pready) begin
            next_pslverr = accessErr;
            next_prdata = (pwrite || accessErr) ? 32'h0000_0000 : rdMux;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic next_pdEnable;
    logic next_fuseSet;
    logic next_refused;
    logic [9:0] next_polarity;
    logic [9:0] next_outEnable;

    always_comb begin
        next_pdEnable = pdEnable;
        next_fuseSet = fuseSet;
        next_refused = refused;
        next_polarity = polarity;
        next_outEnable = outEnable;
        if (wrDone && paddr == prs_pkg::ADDR_CTRL) begin
            next_pdEnable = pwdata[prs_pkg::CTRL_PD_ENABLE_BIT];
        end
        if (wrDone && paddr == prs_pkg::ADDR_POLARITY) begin
            next_polarity = pwdata[9:0];
        end
        if (wrDone && paddr == prs_pkg::ADDR_OUT_ENABLE) begin
            next_outEnable = pwdata[9:0];
        end
        if (wrDone && paddr == prs_pkg::ADDR_SECURE
            && pwdata[prs_pkg::SECURE_FUSE_BIT]) begin
            next_fuseSet = 1'b1;
        end
        if (wrDone && paddr == prs_pkg::ADDR_STATUS
            && pwdata[prs_pkg::STAT_REFUSED_BIT]) begin
            next_refused = 1'b0;
        end
        if (xferDone && pslverr) begin
            next_refused = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pdEnable <= prs_pkg::PD_ENABLE_RESET;
            fuseSet <= prs_pkg::FUSE_RESET;
            refused <= 1'b0;
            polarity <= prs_pkg::POLARITY_RESET;
            outEnable <= prs_pkg::OUT_ENABLE_RESET;
        end else begin
            pdEnable <= next_pdEnable;
            fuseSet <= next_fuseSet;
            refused <= next_refused;
            polarity <= next_polarity;
            outEnable <= next_outEnable;
        end
    end

    // ****************************************************************
    // sequencer and macrocells
    // ****************************************************************
    logic clkPrev;
    logic clkRise;
    logic sleepReq;
    logic preloadWr;
    logic [9:0] arrayIn;
    prs_pkg::prs_state_t next_state;
    logic [7:0] next_porstCnt;
    logic [9:0] next_cells;
    logic [9:0] next_cellOut;
    logic [9:0] next_cellOutEn;

    assign clkRise = arrayClkS & ~clkPrev;
    assign sleepReq = pdEnable & sleepPinS;
    assign preloadWr = wrDone & (paddr == prs_pkg::ADDR_PRELOAD);
    // shared pin feeds the array only when power-down is off
    assign arrayIn = logicInS ^ {9'h000, ~pdEnable & sleepPinS};

    always_comb begin
        next_state = state;
        next_porstCnt = porstCnt;
        next_cells = cells;
        next_cellOut = cellOut;
        next_cellOutEn = cellOutEn;
        case (state)
            prs_pkg::PRS_PORST: begin
                next_cells = 10'h000;
                next_cellOut = polarity;
                next_cellOutEn = outEnable;
                next_porstCnt = porstCnt + 8'h01;
                if (porstCnt == prs_pkg::PORST_LAST) begin
                    next_state = prs_pkg::PRS_RUN;
                end
            end
            prs_pkg::PRS_RUN: begin
                if (preloadWr) begin
                    next_cells = pwdata[9:0];
                end else if (clkRise) begin
                    next_cells = arrayIn;
                end
                next_cellOut = cells ^ polarity;
                next_cellOutEn = outEnable;
                if (sleepReq) begin
                    next_state = prs_pkg::PRS_SLEEP;
                end
            end
            prs_pkg::PRS_SLEEP: begin
                // everything holds; clock and inputs ignored
                if (!sleepReq) begin
                    next_state = prs_pkg::PRS_RUN;
                end
            end
            default: begin
                next_state = prs_pkg::PRS_PORST;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= prs_pkg::PRS_PORST;
            porstCnt <= 8'h00;
            cells <= 10'h000;
            cellOut <= 10'h000;
            cellOutEn <= 10'h000;
            clkPrev <= 1'b0;
        end else begin
            state <= next_state;
            porstCnt <= next_porstCnt;
            cells <= next_cells;
            cellOut <= next_cellOut;
            cellOutEn <= next_cellOutEn;
            clkPrev <= arrayClkS;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_porst_clear;
        @(posedge clk_sys) disable iff (srst)
        $fell(srst) |-> (state == prs_pkg::PRS_PORST && cells == 10'h000)[*8];
    endproperty
    a_porst_clear: assert property (p_porst_clear)
        else $error("cells not held clear during power-up reset");

    property p_porst_polarity;
        @(posedge clk_sys) disable iff (srst)
        ($past(state) == prs_pkg::PRS_PORST && $past(porstCnt) != 8'h00)
            |-> cellOut == $past(polarity);
    endproperty
    a_porst_polarity: assert property (p_porst_polarity)
        else $error("output after clear does not follow polarity");

    property p_sleep_hold_data;
        @(posedge clk_sys) disable iff (srst)
        (state == prs_pkg::PRS_SLEEP) |=> $stable(cellOut) && $stable(cells);
    endproperty
    a_sleep_hold_data: assert property (p_sleep_hold_data)
        else $error("output data moved during power-down");

    property p_sleep_hold_hiz;
        @(posedge clk_sys) disable iff (srst)
        (state == prs_pkg::PRS_SLEEP && !cellOutEn[0])
            |=> !cellOutEn[0] && $stable(cellOutEn);
    endproperty
    a_sleep_hold_hiz: assert property (p_sleep_hold_hiz)
        else $error("disabled output enabled during power-down");

    property p_sleep_ignore_clk;
        @(posedge clk_sys) disable iff (srst)
        (state == prs_pkg::PRS_SLEEP && clkRise && arrayIn != cells)
            |=> cells == $past(cells);
    endproperty
    a_sleep_ignore_clk: assert property (p_sleep_ignore_clk)
        else $error("register updated from clock in power-down");

    property p_preload;
        @(posedge clk_sys) disable iff (srst)
        preloadWr |=> cells == $past(pwdata[9:0]);
    endproperty
    a_preload: assert property (p_preload)
        else $error("preload value not forced into registers");

    property p_sig_open;
        @(posedge clk_sys) disable iff (srst)
        (xferDone && fuseSet && prs_pkg::prs_is_sig(paddr)) |-> !pslverr;
    endproperty
    a_sig_open: assert property (p_sig_open)
        else $error("signature access refused while secured");

    property p_secure_block;
        @(posedge clk_sys) disable iff (srst)
        (setupPh && fuseSet && paddr == prs_pkg::ADDR_VERIFY)
            |-> ##2 (pready && pslverr && prdata == 32'h0000_0000);
    endproperty
    a_secure_block: assert property (p_secure_block)
        else $error("verify allowed while secured");

    property p_sleep_entry;
        @(posedge clk_sys) disable iff (srst)
        (state == prs_pkg::PRS_RUN && pdEnable && sleepPinS)
            |=> state == prs_pkg::PRS_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("high sleep pin did not enter power-down");

    property p_pd_disabled;
        @(posedge clk_sys) disable iff (srst)
        (!pdEnable && state == prs_pkg::PRS_RUN) |=> state != prs_pkg::PRS_SLEEP;
    endproperty
    a_pd_disabled: assert property (p_pd_disabled)
        else $error("power-down entered with feature disabled");

endmodule : prs_sequencer_top

// *** src/prs_sig_mem.sv ***
// user signature store, two words with registered read
`timescale 1ns/1ns
module prs_sig_mem (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // write side
    input wire logic wrEn,
    input wire logic wrSel,
    input wire logic [31:0] wrData,
    // read side
    input wire logic rdSel,
    output logic [31:0] rdData
);

    logic [31:0] words [prs_pkg::SIG_WORDS];
    logic [31:0] next_words [prs_pkg::SIG_WORDS];
    logic [31:0] next_rdData;

    always_comb begin
        next_words = words;
        if (wrEn) begin
            next_words[wrSel] = wrData;
        end
        next_rdData = words[rdSel];
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            words[0] <= prs_pkg::SIG_RESET;
            words[1] <= prs_pkg::SIG_RESET;
            rdData <= prs_pkg::SIG_RESET;
        end else begin
            words <= next_words;
            rdData <= next_rdData;
        end
    end

endmodule : prs_sig_mem

// *** tb/prs_board_model.sv ***
// board-side driver of the array clock, logic inputs and sleep pin
`timescale 1ns/1ns
module prs_board_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // requests from the bench
    input wire logic clkReq,
    input wire logic [9:0] inReq,
    input wire logic sleepReq,
    output logic busy,
    // device pins
    output logic arrayClkPin,
    output logic [9:0] logicInPin,
    output logic input_or_sleep_pin
);
    // ****************************************************************
    // pin driver
    // ****************************************************************
    logic [7:0] quietCnt;
    logic [3:0] phase;

    assign busy = (phase != 4'h0);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            quietCnt <= 8'h00;
            phase <= 4'h0;
            arrayClkPin <= 1'b0;
            logicInPin <= 10'h000;
            input_or_sleep_pin <= 1'b0;
        end else begin
            input_or_sleep_pin <= sleepReq;
            // clock held still well past the power-up reset time
            if (quietCnt < 8'h10) begin
                quietCnt <= quietCnt + 8'h01;
            end
            // inputs settle three cycles before the clock rises
            if (phase == 4'h0) begin
                if (clkReq && quietCnt >= 8'h10) begin
                    logicInPin <= inReq;
                    phase <= 4'h1;
                end
            end else begin
                arrayClkPin <= (phase >= 4'h3) && (phase < 4'h7);
                phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
            end
        end
    end
endmodule : prs_board_model

// *** tb/prs_sequencer_top_tb.sv ***
// self-checking bench for the housekeeping sequencer
`timescale 1ns/1ns
module prs_sequencer_top_tb;
    // ****************************************************************
    // signals, instances and helpers
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic arrayClkPin;
    logic [9:0] logicInPin;
    logic input_or_sleep_pin;
    logic [9:0] cellOut;
    logic [9:0] cellOutEn;
    logic clkReq = 1'b0;
    logic [9:0] inReq = 10'h000;
    logic sleepReq = 1'b0;
    logic busy;
    logic [31:0] rd;
    logic err;
    int failCount = 0;
    int compares = 0;
    int cycles = 0;

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    prs_sequencer_top prs_sequencer_top_inst (.clk_sys(clk_sys),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arrayClkPin(arrayClkPin),
        .logicInPin(logicInPin), .input_or_sleep_pin(input_or_sleep_pin),
        .cellOut(cellOut), .cellOutEn(cellOutEn));

    prs_board_model prs_board_model_inst (.clk_sys(clk_sys), .srst(srst),
        .clkReq(clkReq), .inReq(inReq), .sleepReq(sleepReq), .busy(busy),
        .arrayClkPin(arrayClkPin), .logicInPin(logicInPin),
        .input_or_sleep_pin(input_or_sleep_pin));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failCount++;
            $display("unexpected at %0t: run too long", $time);
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_n

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input logic e);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp, "read data");
        check(32'(err), 32'(e), "error response");
    endtask : rdchk

    task automatic pulse(input logic [9:0] v);
        @(posedge clk_sys);
        clkReq <= 1'b1;
        inReq <= v;
        while (busy !== 1'b1) @(posedge clk_sys);
        clkReq <= 1'b0;
        while (busy !== 1'b0) @(posedge clk_sys);
        wait_n(4);
    endtask : pulse

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_porst();
        logic [7:0] zeroRegs [7];
        zeroRegs = '{prs_pkg::ADDR_CTRL, prs_pkg::ADDR_POLARITY,
            prs_pkg::ADDR_OUT_ENABLE, prs_pkg::ADDR_PRELOAD,
            prs_pkg::ADDR_SECURE, prs_pkg::ADDR_SIG_LO, prs_pkg::ADDR_SIG_HI};
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0004, 1'b0);
        apb(1'b1, prs_pkg::ADDR_PRELOAD, 32'h0000_03FF);
        check(32'(err), 32'h0000_0001, "preload in reset");
        rdchk(prs_pkg::ADDR_CELLS, 32'h0000_0000, 1'b0);
        wait_n(14);
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0008, 1'b0);
        apb(1'b1, prs_pkg::ADDR_STATUS, 32'h0000_0008);
        foreach (zeroRegs[i]) rdchk(zeroRegs[i], 32'h0000_0000, 1'b0);
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
        rdchk(8'h30, 32'h0000_0000, 1'b1);
        // refusal flag is sticky; clear it for the later status reads
        apb(1'b1, prs_pkg::ADDR_STATUS, 32'h0000_0008);
        $display("test power-up reset done");
    endtask : t_porst

    task automatic t_polarity();
        apb(1'b1, prs_pkg::ADDR_POLARITY, 32'h0000_02A5);
        apb(1'b1, prs_pkg::ADDR_OUT_ENABLE, 32'h0000_03FF);
        wait_n(3);
        check(32'(cellOut), 32'h0000_02A5, "cleared level");
        check(32'(cellOutEn), 32'h0000_03FF, "output enables");
        rdchk(prs_pkg::ADDR_VERIFY, 32'h03FF_02A5, 1'b0);
        $display("test polarity done");
    endtask : t_polarity

    task automatic t_preload();
        logic [31:0] vals [3];
        vals = '{32'h0000_03C3, 32'h0000_0000, 32'h0000_03FF};
        foreach (vals[i]) begin
            apb(1'b1, prs_pkg::ADDR_PRELOAD, vals[i]);
            check(32'(err), 32'h0000_0000, "preload ok");
            rdchk(prs_pkg::ADDR_CELLS, vals[i], 1'b0);
            check(32'(cellOut), vals[i] ^ 32'h0000_02A5, "out");
        end
        $display("test preload done");
    endtask : t_preload

    task automatic t_array();
        sleepReq <= 1'b1;
        wait_n(5);
        pulse(10'h155);
        rdchk(prs_pkg::ADDR_CELLS, 32'h0000_0154, 1'b0);
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
        $display("test shared pin as input done");
    endtask : t_array

    task automatic t_sleep();
        sleepReq <= 1'b0;
        apb(1'b1, prs_pkg::ADDR_CTRL, 32'h0000_0001);
        // bit 0 disabled on entry, so it must stay disabled while asleep
        apb(1'b1, prs_pkg::ADDR_OUT_ENABLE, 32'h0000_03FE);
        wait_n(5);
        sleepReq <= 1'b1;
        wait_n(6);
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0001, 1'b0);
        pulse(10'h0F0);
        apb(1'b1, prs_pkg::ADDR_OUT_ENABLE, 32'h0000_0001);
        apb(1'b1, prs_pkg::ADDR_PRELOAD, 32'h0000_03FF);
        check(32'(err), 32'h0000_0001, "preload asleep");
        check(32'(cellOut), 32'h0000_03F1, "held level");
        check(32'(cellOutEn), 32'h0000_03FE, "held enables");
        rdchk(prs_pkg::ADDR_CELLS, 32'h0000_0154, 1'b0);
        sleepReq <= 1'b0;
        wait_n(6);
        check(32'(cellOutEn), 32'h0000_0001, "wake enables");
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_0008, 1'b0);
        apb(1'b1, prs_pkg::ADDR_STATUS, 32'h0000_0008);
        $display("test power-down done");
    endtask : t_sleep

    task automatic t_secure();
        apb(1'b1, prs_pkg::ADDR_SIG_LO, 32'h1234_5678);
        apb(1'b1, prs_pkg::ADDR_SIG_HI, 32'h9ABC_DEF0);
        apb(1'b1, prs_pkg::ADDR_SECURE, 32'h0000_0001);
        rdchk(prs_pkg::ADDR_VERIFY, 32'h0000_0000, 1'b1);
        apb(1'b1, prs_pkg::ADDR_PRELOAD, 32'h0000_0000);
        check(32'(err), 32'h0000_0001, "preload secured");
        rdchk(prs_pkg::ADDR_SIG_LO, 32'h1234_5678, 1'b0);
        rdchk(prs_pkg::ADDR_SIG_HI, 32'h9ABC_DEF0, 1'b0);
        rdchk(prs_pkg::ADDR_STATUS, 32'h0000_000A, 1'b0);
        rdchk(prs_pkg::ADDR_CELLS, 32'h0000_0154, 1'b0);
        @(posedge clk_sys);
        srst <= 1'b1;
        wait_n(4);
        srst <= 1'b0;
        rdchk(prs_pkg::ADDR_CELLS, 32'h0000_0000, 1'b0);
        check(32'(cellOut), 32'h0000_0000, "level after reset");
        rdchk(prs_pkg::ADDR_SECURE, 32'h0000_0000, 1'b0);
        $display("test security done");
    endtask : t_secure

    initial begin
        wait_n(4);
        srst <= 1'b0;
        t_porst();
        t_polarity();
        t_preload();
        t_array();
        t_sleep();
        t_secure();
        conclude();
    end
endmodule : prs_sequencer_top_tb
